// ==== mgec_regs.svh ====
/*
 * Constants of the matrix GPIO edge counter: widths, group view codes,
 * reset values and scan timing counts.
 * Assumes one 200 MHz system clock; included by bare name.
 */
`ifndef MGEC_REGS_SVH
`define MGEC_REGS_SVH

`define MGEC_NUM_LINES 31
`define MGEC_SCAN_LINES 24
`define MGEC_CNT_W 32
`define MGEC_GRP_W 8
`define MGEC_MAX_KEYS 144

// Group view select codes
`define MGEC_GRP_LOW_BYTE 3'h0
`define MGEC_GRP_HIGH_BYTE 3'h1
`define MGEC_GRP_EVEN_LINES 3'h2
`define MGEC_GRP_ODD_LINES 3'h3
`define MGEC_GRP_UPPER_BYTE 3'h4

// Reset values
`define MGEC_RST_MASK 31'h0000_0000
`define MGEC_RST_PULL 31'h7FFF_FFFF
`define MGEC_RST_OUT 31'h7FFF_FFFF

// Scan timing
`define MGEC_CLK_PERIOD_NS 5
`define MGEC_SCAN_STEP_NS 2000
`define MGEC_SCAN_STEP_CYC ((`MGEC_SCAN_STEP_NS + `MGEC_CLK_PERIOD_NS - 1) / `MGEC_CLK_PERIOD_NS)

`endif

// ==== mgec_pkg.sv ====
/*
 * Types of the matrix GPIO edge counter: scanner states, key record.
 * Assumes mgec_regs.svh for the widths.
 */
`include "mgec_regs.svh"

package mgec_pkg;

    typedef enum logic [1:0] {
        SC_BASE = 2'b00,
        SC_DRIVE = 2'b01,
        SC_PUBLISH = 2'b10
    } mgec_scan_st_e;

    typedef struct packed {
        logic valid;
        logic [4:0] line_a;
        logic [4:0] line_b;
    } mgec_key_s;

    typedef logic [`MGEC_NUM_LINES-1:0] mgec_lines_t;
    typedef logic [`MGEC_SCAN_LINES-1:0] mgec_scan_t;

endpackage : mgec_pkg

// ==== mgec_scan.sv ====
/*
 * Key matrix scanner: drives one scan line low at a time and senses
 * the higher scan lines, reporting up to two joined line pairs.
 * Assumes synchronised line levels and pull-ups on every scan line.
 */
`timescale 1ns/1ps

module mgec_scan
    import mgec_pkg::*;
#(
    parameter int STEP_CYC = `MGEC_SCAN_STEP_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Line side
    input wire mgec_scan_t en_i,
    input wire mgec_scan_t lvl_i,
    output mgec_scan_t drive_o,
    // Key report
    output mgec_key_s key0_o,
    output mgec_key_s key1_o,
    output logic key_evt_o
);

    typedef struct packed {
        mgec_scan_st_e st;
        logic [15:0] tick;
        logic [4:0] idx;
        mgec_scan_t gnd;
        logic [1:0] nk;
        mgec_key_s k0;
        mgec_key_s k1;
        mgec_key_s p0;
        mgec_key_s p1;
        logic evt;
    } mgec_scan_s;

    mgec_scan_s s_q, s_d;
    mgec_scan_t sense;
    logic tick_hit;

    always_comb begin
        s_d = s_q;
        s_d.evt = 1'b0;
        sense = '0;
        tick_hit = (s_q.tick == 16'(STEP_CYC - 1));
        s_d.tick = tick_hit ? 16'h0000 : s_q.tick + 16'h0001;
        case (s_q.st)
            SC_BASE: begin
                if (tick_hit) begin
                    // Lines already low at sweep start count as grounded and are left out of the matrix
                    s_d.gnd = ~lvl_i & en_i;
                    s_d.idx = 5'h00;
                    s_d.nk = 2'h0;
                    s_d.k0 = '0;
                    s_d.k1 = '0;
                    s_d.st = SC_DRIVE;
                end
            end
            SC_DRIVE: begin
                if (tick_hit) begin
                    // Only lines above the driver: each pair is seen once
                    for (int j = 0; j < `MGEC_SCAN_LINES; j++) begin
                        sense[j] = ~lvl_i[j] & en_i[j] & ~s_q.gnd[j] & (j > s_q.idx);
                    end
                    if (!(en_i[s_q.idx] && !s_q.gnd[s_q.idx])) begin
                        sense = '0;
                    end
                    // Two simultaneous keys are kept; a third is dropped
                    for (int j = `MGEC_SCAN_LINES - 1; j >= 0; j--) begin
                        if (sense[j] && s_d.nk == 2'h0) begin
                            s_d.k0 = '{1'b1, s_q.idx, 5'(j)};
                        end
                    end
                    for (int j = 0; j < `MGEC_SCAN_LINES; j++) begin
                        if (sense[j] && s_d.nk != 2'h2) begin
                            if (s_d.nk == 2'h0) begin
                                s_d.nk = 2'h1;
                            end else if (5'(j) != s_d.k0.line_b || s_q.idx != s_d.k0.line_a) begin
                                s_d.k1 = '{1'b1, s_q.idx, 5'(j)};
                                s_d.nk = 2'h2;
                            end
                        end
                    end
                    if (s_q.idx == 5'(`MGEC_SCAN_LINES - 1)) begin
                        s_d.st = SC_PUBLISH;
                    end else begin
                        s_d.idx = s_q.idx + 5'h01;
                    end
                end
            end
            SC_PUBLISH: begin
                if (s_q.k0 != s_q.p0 || s_q.k1 != s_q.p1) begin
                    s_d.p0 = s_q.k0;
                    s_d.p1 = s_q.k1;
                    s_d.evt = s_q.k0.valid;
                end
                s_d.st = SC_BASE;
            end
            default: begin
                s_d.st = SC_BASE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        drive_o = '0;
        if (s_q.st == SC_DRIVE && en_i[s_q.idx] && !s_q.gnd[s_q.idx]) begin
            drive_o[s_q.idx] = 1'b1;
        end
    end

    assign key0_o = s_q.p0;
    assign key1_o = s_q.p1;
    assign key_evt_o = s_q.evt;

endmodule : mgec_scan

// ==== mgec_top.sv ====
/*
 * Matrix GPIO edge counter: 31 user lines with configuration masks,
 * single-bit and 8-bit group access, edge events, per-line edge
 * counters and a key matrix scanner on the lower 24 lines.
 * Assumes inputs synchronous to mclk_i and a pad that resolves the
 * line from pad_out_o, pad_oe_n_o and pad_pull_o.
 */

`timescale 1ns/1ps

module mgec_top
    import mgec_pkg::*;
#(
    parameter int NUM_LINES = `MGEC_NUM_LINES,
    parameter int CNT_W = `MGEC_CNT_W,
    parameter int SCAN_STEP_CYC = `MGEC_SCAN_STEP_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Configuration, taken on cfg_load_i
    input wire logic cfg_load_i,
    input wire mgec_lines_t active_mask_i,
    input wire mgec_lines_t dir_in_mask_i,
    input wire mgec_lines_t edge_irq_mask_i,
    input wire mgec_lines_t edge_rise_mask_i,
    input wire mgec_lines_t scan_mask_i,
    input wire mgec_lines_t pullup_mask_i,
    // Pins claimed by other on-chip functions
    input wire mgec_lines_t claimed_mask_i,
    // Single-bit access
    input wire logic bit_wr_i,
    input wire logic [4:0] bit_sel_i,
    input wire logic bit_val_i,
    output mgec_lines_t line_level_o,
    // Group access
    input wire logic grp_wr_i,
    input wire logic [2:0] grp_sel_i,
    input wire logic [7:0] grp_data_i,
    input wire logic [2:0] grp_rd_sel_i,
    output logic [7:0] grp_rd_data_o,
    // Edge events and counters
    output mgec_lines_t edge_evt_o,
    input wire logic cnt_clr_i,
    input wire logic [4:0] cnt_clr_sel_i,
    input wire logic [4:0] cnt_rd_sel_i,
    output logic [CNT_W-1:0] cnt_val_o,
    // Key matrix report
    output mgec_key_s key0_o,
    output mgec_key_s key1_o,
    output logic key_evt_o,
    // Pads
    input wire mgec_lines_t pad_in_i,
    output mgec_lines_t pad_out_o,
    output mgec_lines_t pad_oe_n_o,
    output mgec_lines_t pad_pull_o
);

    typedef struct packed {
        logic cfg_ok;
        mgec_lines_t active;
        mgec_lines_t dir_in;
        mgec_lines_t trig;
        mgec_lines_t rise;
        mgec_lines_t scan;
        mgec_lines_t pull;
        mgec_lines_t s1;
        mgec_lines_t s2;
        mgec_lines_t prev;
        mgec_lines_t outv;
        mgec_lines_t lvl;
        mgec_lines_t evt;
        mgec_lines_t pout;
        mgec_lines_t oe_n;
        mgec_lines_t pull_o;
        logic [7:0] grp_rd;
        logic [CNT_W-1:0] cnt_rd;
        logic [NUM_LINES-1:0][CNT_W-1:0] cnt;
    } mgec_top_s;

    mgec_top_s s_q, s_d;

    mgec_lines_t own;
    mgec_lines_t gpio_out;
    mgec_lines_t writable;
    mgec_lines_t hit;
    mgec_scan_t scan_en;
    mgec_scan_t scan_drive;
    logic [4:0] gl;

    // Line behind bit k of a group view, lowest line on bit 0
    function automatic logic [4:0] grp_line(input logic [2:0] sel, input int k);
        logic [4:0] r;
        r = 5'(k);
        case (sel)
            `MGEC_GRP_LOW_BYTE: r = 5'(k);
            `MGEC_GRP_HIGH_BYTE: r = 5'(8 + k);
            `MGEC_GRP_EVEN_LINES: r = 5'(2 * k);
            `MGEC_GRP_ODD_LINES: r = 5'(2 * k + 1);
            `MGEC_GRP_UPPER_BYTE: r = 5'(16 + k);
            default: r = 5'(k);
        endcase
        return r;
    endfunction : grp_line

    // Scanner only owns active, unclaimed lines of the lower 24
    assign scan_en = s_q.scan[`MGEC_SCAN_LINES-1:0] & own[`MGEC_SCAN_LINES-1:0];

    mgec_scan #(
        .STEP_CYC(SCAN_STEP_CYC)
    ) u_scan (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(scan_en),
        .lvl_i(s_q.s2[`MGEC_SCAN_LINES-1:0]),
        .drive_o(scan_drive),
        .key0_o(key0_o),
        .key1_o(key1_o),
        .key_evt_o(key_evt_o)
    );

    always_comb begin
        s_d = s_q;
        gl = 5'h00;

        // Claimed pins drop out of every GPIO path
        own = s_q.active & ~claimed_mask_i;
        writable = own & ~s_q.dir_in & ~s_q.scan;
        gpio_out = writable;

        if (cfg_load_i) begin
            s_d.cfg_ok = 1'b1;
            s_d.active = active_mask_i;
            s_d.dir_in = dir_in_mask_i;
            s_d.trig = edge_irq_mask_i;
            s_d.rise = edge_rise_mask_i;
            s_d.scan = scan_mask_i & mgec_lines_t'({`MGEC_SCAN_LINES{1'b1}});
            s_d.pull = pullup_mask_i;
        end

        // Second stage is the only reader of the first
        s_d.s1 = pad_in_i;
        s_d.s2 = s_q.s1;
        s_d.prev = s_q.s2;

        // Edge on the selected polarity of each armed line
        for (int i = 0; i < NUM_LINES; i++) begin
            hit[i] = s_q.trig[i] & own[i] & ~s_q.scan[i] &
                     (s_q.rise[i] ? (s_q.s2[i] & ~s_q.prev[i])
                                  : (~s_q.s2[i] & s_q.prev[i]));
        end
        s_d.evt = hit;

        // Clear first, so an edge in the same cycle still counts
        for (int i = 0; i < NUM_LINES; i++) begin
            if (cnt_clr_i && cnt_clr_sel_i == 5'(i)) begin
                s_d.cnt[i] = '0;
            end
            if (hit[i]) begin
                s_d.cnt[i] = s_d.cnt[i] + CNT_W'(1);
            end
        end

        // Group write before bit write: the bit wins on overlap
        if (grp_wr_i) begin
            for (int k = 0; k < `MGEC_GRP_W; k++) begin
                gl = grp_line(grp_sel_i, k);
                if (writable[gl]) begin
                    s_d.outv[gl] = grp_data_i[k];
                end
            end
        end
        if (bit_wr_i && bit_sel_i < 5'(NUM_LINES) && writable[bit_sel_i]) begin
            s_d.outv[bit_sel_i] = bit_val_i;
        end

        // Readback of synchronised levels on enabled lines
        s_d.lvl = s_q.s2 & own;
        for (int k = 0; k < `MGEC_GRP_W; k++) begin
            gl = grp_line(grp_rd_sel_i, k);
            s_d.grp_rd[k] = s_q.s2[gl] & own[gl];
        end
        s_d.cnt_rd = (cnt_rd_sel_i < 5'(NUM_LINES)) ? s_q.cnt[cnt_rd_sel_i] : '0;

        // Pad drive: GPIO outputs, else scanner pulls its line low
        for (int i = 0; i < NUM_LINES; i++) begin
            s_d.pout[i] = gpio_out[i] & s_q.outv[i];
            s_d.oe_n[i] = ~gpio_out[i];
            if (i < `MGEC_SCAN_LINES) begin
                if (scan_drive[i]) begin
                    s_d.pout[i] = 1'b0;
                    s_d.oe_n[i] = 1'b0;
                end
            end
        end

        // Until configured every line idles pulled high
        if (!s_q.cfg_ok) begin
            s_d.pull_o = mgec_lines_t'(`MGEC_RST_PULL);
        end else begin
            // Scan lines need their pull-up to read an open key
            s_d.pull_o = ((s_q.pull & own & s_q.dir_in) | (s_q.scan & own)) &
                         ~claimed_mask_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.outv <= mgec_lines_t'(`MGEC_RST_OUT);
            s_q.oe_n <= mgec_lines_t'({`MGEC_NUM_LINES{1'b1}});
            s_q.pull_o <= mgec_lines_t'(`MGEC_RST_PULL);
            // Pads idle pulled high: avoids a false edge after reset
            s_q.s1 <= '1;
            s_q.s2 <= '1;
            s_q.prev <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign line_level_o = s_q.lvl;
    assign grp_rd_data_o = s_q.grp_rd;
    assign edge_evt_o = s_q.evt;
    assign cnt_val_o = s_q.cnt_rd;
    assign pad_out_o = s_q.pout;
    assign pad_oe_n_o = s_q.oe_n;
    assign pad_pull_o = s_q.pull_o;

endmodule : mgec_top

// ==== mgec_top_monitor.sv ====
/*
 * Port checker of the matrix GPIO edge counter.
 * Assumes binding to mgec_top; sees only its ports.
 */
`timescale 1ns/1ps

module mgec_top_monitor
    import mgec_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock, reset, control
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cfg_load_i,
    input wire mgec_lines_t claimed_mask_i,
    input wire logic cnt_clr_i,
    input wire logic [4:0] cnt_clr_sel_i,
    input wire logic [4:0] cnt_rd_sel_i,
    // Observed results
    input wire logic [CNT_W-1:0] cnt_val_o,
    input wire mgec_lines_t line_level_o,
    input wire mgec_lines_t edge_evt_o,
    input wire mgec_key_s key0_o,
    input wire logic key_evt_o,
    // Pads
    input wire mgec_lines_t pad_in_i,
    input wire mgec_lines_t pad_out_o,
    input wire mgec_lines_t pad_oe_n_o,
    input wire mgec_lines_t pad_pull_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    logic cfg_seen_q;
    mgec_lines_t claim1_q;
    mgec_lines_t claim2_q;
    always_ff @(posedge mclk_i) begin
        cfg_seen_q <= rst_n_i & (cfg_seen_q | cfg_load_i);
        claim1_q <= claimed_mask_i;
        claim2_q <= claim1_q & claimed_mask_i;
    end

    reset_state_a: assert property (disable iff (1'b0) !rst_n_i |=> pad_pull_o == '1
        && pad_oe_n_o == '1 && pad_out_o == '0 && edge_evt_o == '0 && !key_evt_o)
        else $error("pads not released high after reset");
    pull_until_cfg_a: assert property (!cfg_seen_q |-> pad_pull_o == '1)
        else $error("pull-up dropped before configuration");
    evt_cause_a: assert property (edge_evt_o != '0 |-> (edge_evt_o & ~(($past(pad_in_i, 2)
        ^ $past(pad_in_i, 3)) | ($past(pad_in_i, 3) ^ $past(pad_in_i, 4)))) == '0)
        else $error("edge event without a pin change");
    key_valid_a: assert property (key_evt_o |-> key0_o.valid)
        else $error("key event with no valid key");
    key_order_a: assert property (key0_o.valid |-> key0_o.line_a < key0_o.line_b
        && key0_o.line_b < 5'd24) else $error("key pair outside scan lines");
    key_pulse_a: assert property (key_evt_o |=> !key_evt_o)
        else $error("key event longer than one cycle");
    claim_free_a: assert property ((claim2_q & claim1_q & claimed_mask_i
        & (~pad_oe_n_o | line_level_o)) == '0) else $error("claimed line still in use");
    cnt_none_a: assert property (cnt_rd_sel_i == 5'h1F |=> cnt_val_o == '0)
        else $error("counter read beyond last line");
    clr_zero_a: assert property (cnt_clr_i && cnt_rd_sel_i == cnt_clr_sel_i
        ##1 $stable(cnt_rd_sel_i) |=> cnt_val_o <= CNT_W'(1)) else $error("counter not cleared");
    cnt_step_a: assert property ($stable(cnt_rd_sel_i) && !$past(cnt_clr_i)
        |=> cnt_val_o - $past(cnt_val_o) <= CNT_W'(1)) else $error("counter stepped by more than one");
endmodule : mgec_top_monitor

bind mgec_top mgec_top_monitor #(.CNT_W(CNT_W)) u_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cfg_load_i(cfg_load_i), .claimed_mask_i(claimed_mask_i), .cnt_clr_i(cnt_clr_i),
    .cnt_clr_sel_i(cnt_clr_sel_i), .cnt_rd_sel_i(cnt_rd_sel_i), .cnt_val_o(cnt_val_o),
    .line_level_o(line_level_o), .edge_evt_o(edge_evt_o), .key0_o(key0_o),
    .key_evt_o(key_evt_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .pad_pull_o(pad_pull_o));

// ==== mgec_keypad_model.sv ====
/*
 * Board model: switches, grounded lines and a diode-free key matrix.
 * Assumes pad outputs of mgec_top; lines with no driver and no pull float.
 */
`timescale 1ns/1ps

module mgec_keypad_model
    import mgec_pkg::*;
(
    // Pads
    input wire logic mclk_i,
    input wire mgec_lines_t pad_out_i,
    input wire mgec_lines_t pad_oe_n_i,
    input wire mgec_lines_t pad_pull_i,
    output mgec_lines_t pad_in_o,
    // Switches and held keys
    input wire mgec_lines_t ext_en_i,
    input wire mgec_lines_t ext_val_i,
    input wire mgec_key_s key0_i,
    input wire mgec_key_s key1_i
);
    mgec_lines_t last_q = '0;
    mgec_lines_t base;
    always_ff @(posedge mclk_i) begin
        last_q <= pad_in_o;
    end
    always_comb begin
        for (int i = 0; i < 31; i++) begin
            if (!pad_oe_n_i[i]) base[i] = pad_out_i[i];
            else if (ext_en_i[i]) base[i] = ext_val_i[i];
            else if (pad_pull_i[i]) base[i] = 1'b1;
            else base[i] = ~last_q[i];
        end
        pad_in_o = base;
        // Plain contact: a low on either side wins
        if (key0_i.valid) begin
            pad_in_o[key0_i.line_a] = base[key0_i.line_a] & base[key0_i.line_b];
            pad_in_o[key0_i.line_b] = base[key0_i.line_a] & base[key0_i.line_b];
        end
        if (key1_i.valid) begin
            pad_in_o[key1_i.line_a] = base[key1_i.line_a] & base[key1_i.line_b];
            pad_in_o[key1_i.line_b] = base[key1_i.line_a] & base[key1_i.line_b];
        end
    end
endmodule : mgec_keypad_model

// ==== tb.sv ====
/*
 * Testbench of mgec_top: masks, bit and group access, counters, keys.
 * Assumes a short scan step so a sweep lasts some 200 cycles.
 */
`timescale 1ns/1ps

module tb;
    import mgec_pkg::*;
    localparam int STEP = 8;
    localparam mgec_lines_t OUTM = 31'h00F0_FFF0;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, cfg_load_i = 1'b0, bit_wr_i = 1'b0, bit_val_i = 1'b0;
    logic grp_wr_i = 1'b0, cnt_clr_i = 1'b0, key_evt_o;
    logic [4:0] bit_sel_i = '0, cnt_clr_sel_i = '0, cnt_rd_sel_i = '0;
    logic [2:0] grp_sel_i = '0, grp_rd_sel_i = '0;
    logic [7:0] grp_data_i = '0, grp_rd_data_o;
    logic [31:0] cnt_val_o;
    mgec_lines_t act = 31'h00FF_FFFF, claimed_mask_i = '0, ext_en = 31'h7, ext_val = 31'h7;
    mgec_lines_t line_level_o, edge_evt_o, pad_in_i, pad_out_o, pad_oe_n_o, pad_pull_o, expo;
    mgec_key_s key0_o, key1_o, k0 = '0, k1 = '0;
    int error_cnt = 0, samples_checked = 0, kev = 0, ev0 = 0, ev1 = 0;

    always #2.5 mclk_i = ~mclk_i;
    // Pulses are counted mid-cycle, where they have settled
    always @(negedge mclk_i) begin
        if (key_evt_o === 1'b1) kev++;
        if (edge_evt_o[0] === 1'b1) ev0++;
        if (edge_evt_o[1] === 1'b1) ev1++;
    end

    mgec_top #(.SCAN_STEP_CYC(STEP)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .cfg_load_i(cfg_load_i), .active_mask_i(act), .dir_in_mask_i(31'hF),
        .edge_irq_mask_i(31'h3), .edge_rise_mask_i(31'h2), .scan_mask_i(31'hF_0000),
        .pullup_mask_i(31'h5), .claimed_mask_i(claimed_mask_i), .bit_wr_i(bit_wr_i),
        .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i), .line_level_o(line_level_o),
        .grp_wr_i(grp_wr_i), .grp_sel_i(grp_sel_i), .grp_data_i(grp_data_i),
        .grp_rd_sel_i(grp_rd_sel_i), .grp_rd_data_o(grp_rd_data_o), .edge_evt_o(edge_evt_o),
        .cnt_clr_i(cnt_clr_i), .cnt_clr_sel_i(cnt_clr_sel_i), .cnt_rd_sel_i(cnt_rd_sel_i),
        .cnt_val_o(cnt_val_o), .key0_o(key0_o), .key1_o(key1_o), .key_evt_o(key_evt_o),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .pad_pull_o(pad_pull_o));
    mgec_keypad_model u_pad (.mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pad_pull_i(pad_pull_o), .pad_in_o(pad_in_i), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .key0_i(k0), .key1_i(k1));

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rd_cnt(input logic [4:0] sel, input logic [31:0] exp);
        cnt_rd_sel_i = sel;
        tick(2);
        chk("counter", exp, cnt_val_o);
    endtask : rd_cnt
    task automatic bit_wr(input logic [4:0] sel, input logic val);
        bit_sel_i = sel;
        bit_val_i = val;
        bit_wr_i = 1'b1;
        tick(1);
        bit_wr_i = 1'b0;
        tick(2);
    endtask : bit_wr
    function automatic int ln(input int v, input int k);
        case (v)
            0: return k;
            1: return 8 + k;
            2: return 2 * k;
            3: return 2 * k + 1;
            default: return 16 + k;
        endcase
    endfunction : ln
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        close_out();
    end

    initial begin
        logic [7:0] d, m;
        tick(20);
        rst_n_i = 1'b1;
        tick(1);
        chk("pull_reset", 32'h7FFF_FFFF, pad_pull_o);
        chk("oe_reset", 32'h7FFF_FFFF, pad_oe_n_o);
        cfg_load_i = 1'b1;
        tick(1);
        cfg_load_i = 1'b0;
        tick(3);
        chk("pull_cfg", 32'h000F_0005, pad_pull_o & act);
        chk("oe_cfg", 32'hF, pad_oe_n_o & OUTM | pad_oe_n_o & 31'hF);
        expo = '1;
        bit_wr(5'd4, 1'b0);
        expo[4] = 1'b0;
        bit_wr(5'd0, 1'b0);
        chk("bit_out", expo & OUTM, pad_out_o & OUTM);
        chk("in_oe", 32'h1, pad_oe_n_o & 31'h1);
        for (int v = 0; v < 5; v++) begin
            d = 8'h5A ^ 8'(v * 37);
            m = '0;
            for (int k = 0; k < 8; k++) begin
                expo[ln(v, k)] = d[k];
                m[k] = OUTM[ln(v, k)];
            end
            grp_sel_i = 3'(v);
            grp_data_i = d;
            grp_wr_i = 1'b1;
            tick(1);
            grp_wr_i = 1'b0;
            grp_rd_sel_i = 3'(v);
            tick(5);
            chk("grp_out", expo & OUTM, pad_out_o & OUTM);
            chk("grp_rd", d & m, grp_rd_data_o & m);
            chk("level", expo & OUTM, line_level_o & OUTM);
        end
        claimed_mask_i = 31'h10;
        tick(4);
        chk("claim", 32'h10, (pad_oe_n_o & ~line_level_o) & 31'h10);
        claimed_mask_i = '0;
        // Edges kept far apart, as a slow switch would
        repeat (3) begin
            ext_val[2:0] = 3'h0;
            tick(10);
            ext_val[2:0] = 3'h7;
            tick(10);
            chk("in_level", 32'h7, line_level_o & 31'h7);
        end
        ext_val[2:0] = 3'h0;
        tick(10);
        rd_cnt(5'd0, 32'd4);
        rd_cnt(5'd1, 32'd3);
        rd_cnt(5'd2, 32'd0);
        chk("evt_fall", 32'd4, 32'(ev0));
        chk("evt_rise", 32'd3, 32'(ev1));
        // Read select on the cleared line arms the clear assertion
        cnt_clr_sel_i = 5'd0;
        cnt_rd_sel_i = 5'd0;
        cnt_clr_i = 1'b1;
        tick(1);
        cnt_clr_i = 1'b0;
        rd_cnt(5'd0, 32'd0);
        rd_cnt(5'd1, 32'd3);
        rd_cnt(5'd31, 32'd0);
        k0 = '{1'b1, 5'd16, 5'd18};
        k1 = '{1'b1, 5'd17, 5'd19};
        tick(700);
        chk("key0", {21'd0, k0}, {21'd0, key0_o});
        chk("key1", {21'd0, k1}, {21'd0, key1_o});
        chk("key_evt", 32'd1, 32'(kev != 0));
        k0 = '0;
        k1 = '0;
        tick(700);
        chk("released", 32'd0, 32'(key0_o.valid));
        ext_en[17] = 1'b1;
        ext_val[17] = 1'b0;
        k0 = '{1'b1, 5'd16, 5'd18};
        tick(700);
        chk("grounded", {21'd0, k0}, {21'd0, key0_o});
        chk("grounded1", 32'd0, 32'(key1_o.valid));
        close_out();
    end
endmodule : tb
